/* File: common/svc_cfg.svh */
// Purpose: register map, field positions and timing counts of the sector verify block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   task-file bytes sit in the low eight bits of each word
`ifndef SVC_CFG_SVH
`define SVC_CFG_SVH

`define SVC_OFF_COUNT    8'h00
`define SVC_OFF_SECTOR   8'h04
`define SVC_OFF_CYL_LO   8'h08
`define SVC_OFF_CYL_HI   8'h0c
`define SVC_OFF_DEVHEAD  8'h10
`define SVC_OFF_OPCODE   8'h14
`define SVC_OFF_CAUSE    8'h18
`define SVC_OFF_COND     8'h1c
`define SVC_OFF_IRQ_STAT 8'h20
`define SVC_OFF_IRQ_MASK 8'h24
`define SVC_OFF_GEOM     8'h28

`define SVC_OP_VERIFY    7'h20
`define SVC_BIT_LBA      6
`define SVC_BIT_DRIVE    4

`define SVC_ERR_UNC      6
`define SVC_ERR_IDN      4
`define SVC_ERR_ABT      2

`define SVC_ST_BSY       7
`define SVC_ST_RDY       6
`define SVC_ST_DF        5
`define SVC_ST_DSC       4
`define SVC_ST_DRQ       3
`define SVC_ST_COR       2
`define SVC_ST_ERR       0

`define SVC_SECTOR_NS    40
`define SVC_CLK_NS       4
`define SVC_SECTOR_CYC   ((`SVC_SECTOR_NS + `SVC_CLK_NS - 1) / `SVC_CLK_NS)

`define SVC_GEOM_RESET   32'h0000_3f10

`endif

/* File: common/svc_pkg.sv */
// Purpose: types shared by the sector verify block
// Assumes: nothing beyond the header of constants
// Notes:   state codes are binary and fixed
package svc_pkg;

  typedef enum logic [1:0] {
    SVC_IDLE  = 2'b00,
    SVC_CHECK = 2'b01,
    SVC_DONE  = 2'b10
  } svc_state_t;

endpackage : svc_pkg

/* File: src/svc_sector_verify.sv */
// Purpose: drive-side verify command (short form) behind an AXI4-Lite task file
// Assumes: the medium checker answers each sector request with a done pulse and
//          an uncorrectable or id-missing indication on the same cycle
// Notes:   no data port at all; verify never asks the host for a transfer
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "svc_cfg.svh"

module svc_sector_verify #(
  parameter int unsigned DRIVE_ID = 0
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // medium checker
  output logic             media_check_req,
  output logic [27:0]      media_check_addr,
  output logic             media_check_lba,
  input  wire logic        media_check_done,
  input  wire logic        media_check_unc,
  input  wire logic        media_check_idnf,
  // interrupt
  output logic             irq
);

  localparam int unsigned SECTOR_CYC = `SVC_SECTOR_CYC;

  svc_pkg::svc_state_t state;

  logic [7:0]  transfer_count;
  logic [7:0]  start_sector_or_lba_low;
  logic [7:0]  cylinder_low_byte;
  logic [7:0]  cylinder_high_byte;
  logic [7:0]  drive_and_head_select;
  logic [7:0]  failure_cause;
  logic [7:0]  drive_condition;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [7:0]  geom_heads;
  logic [7:0]  geom_spt;
  logic [8:0]  remaining;
  logic [7:0]  gap_cnt;
  logic        req_out;
  logic [3:0]  head_next;

  // write channel latches
  logic [7:0]  aw_addr;
  logic        aw_full;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_full;
  logic        do_write;
  logic        cmd_write;
  logic        sector_ok;
  logic        sector_bad;
  logic        lba_mode;
  logic        drive_match;
  logic [15:0] cyl;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;
  assign s_axi_rresp   = 2'b00;
  assign s_axi_arready = !s_axi_rvalid;

  assign lba_mode    = drive_and_head_select[`SVC_BIT_LBA];
  assign drive_match = drive_and_head_select[`SVC_BIT_DRIVE] == DRIVE_ID[0];
  assign cyl         = {cylinder_high_byte, cylinder_low_byte};
  // opcode bit 0 is masked off so both codes start the same verify
  assign cmd_write   = do_write && aw_addr == `SVC_OFF_OPCODE && w_strb[0]
                       && w_data[7:1] == `SVC_OP_VERIFY
                       && state == svc_pkg::SVC_IDLE && drive_match;
  assign sector_ok   = state == svc_pkg::SVC_CHECK && media_check_done
                       && !media_check_unc && !media_check_idnf;
  assign sector_bad  = state == svc_pkg::SVC_CHECK && media_check_done
                       && (media_check_unc || media_check_idnf);

  assign media_check_req  = req_out;
  assign media_check_lba  = lba_mode;
  assign media_check_addr = {drive_and_head_select[3:0], cylinder_high_byte,
                             cylinder_low_byte, start_sector_or_lba_low};
  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_full <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_full <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_bvalid <= 1'b0;
    else if (do_write)
      s_axi_bvalid <= 1'b1;
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        `SVC_OFF_COUNT:    s_axi_rdata <= {24'h00_0000, transfer_count};
        `SVC_OFF_SECTOR:   s_axi_rdata <= {24'h00_0000, start_sector_or_lba_low};
        `SVC_OFF_CYL_LO:   s_axi_rdata <= {24'h00_0000, cylinder_low_byte};
        `SVC_OFF_CYL_HI:   s_axi_rdata <= {24'h00_0000, cylinder_high_byte};
        `SVC_OFF_DEVHEAD:  s_axi_rdata <= {24'h00_0000, drive_and_head_select};
        `SVC_OFF_CAUSE:    s_axi_rdata <= {24'h00_0000, failure_cause};
        `SVC_OFF_COND:     s_axi_rdata <= {24'h00_0000, drive_condition};
        `SVC_OFF_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_status};
        `SVC_OFF_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask};
        `SVC_OFF_GEOM:     s_axi_rdata <= {16'h0000, geom_spt, geom_heads};
        default:           s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // task-file writes are refused while busy so the host cannot move the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_and_head_select <= 8'ha0;
      geom_heads            <= 8'(`SVC_GEOM_RESET);
      geom_spt              <= 8'(`SVC_GEOM_RESET >> 8);
      irq_mask              <= 2'b00;
    end
    else
    begin
      // head tracks the scan; a host write in idle overrides it
      drive_and_head_select[3:0] <= head_next;
      if (do_write && w_strb[0])
      begin
        if (aw_addr == `SVC_OFF_DEVHEAD && state == svc_pkg::SVC_IDLE)
          drive_and_head_select <= w_data[7:0];
        if (aw_addr == `SVC_OFF_IRQ_MASK)
          irq_mask <= w_data[1:0];
        if (aw_addr == `SVC_OFF_GEOM)
        begin
          geom_heads <= w_data[7:0];
          geom_spt   <= w_data[15:8];
        end
      end
    end
  end

  // address registers double as the current position while checking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      transfer_count          <= 8'h01;
      start_sector_or_lba_low <= 8'h01;
      cylinder_low_byte       <= 8'h00;
      cylinder_high_byte      <= 8'h00;
    end
    else if (state == svc_pkg::SVC_IDLE && do_write && w_strb[0])
    begin
      unique case (aw_addr)
        `SVC_OFF_COUNT:  transfer_count          <= w_data[7:0];
        `SVC_OFF_SECTOR: start_sector_or_lba_low <= w_data[7:0];
        `SVC_OFF_CYL_LO: cylinder_low_byte       <= w_data[7:0];
        `SVC_OFF_CYL_HI: cylinder_high_byte      <= w_data[7:0];
        default:         ;
      endcase
    end
    else if (sector_ok)
    begin
      transfer_count <= 8'(remaining - 9'h001);
      if (remaining != 9'h001)
      begin
        if (lba_mode)
          {cylinder_high_byte, cylinder_low_byte, start_sector_or_lba_low} <=
            24'({cylinder_high_byte, cylinder_low_byte, start_sector_or_lba_low}
                + 24'h00_0001);
        else if (start_sector_or_lba_low < geom_spt)
          start_sector_or_lba_low <= start_sector_or_lba_low + 8'h01;
        else
        begin
          start_sector_or_lba_low <= 8'h01;
          if ({4'h0, drive_and_head_select[3:0]} + 8'h01 >= geom_heads)
            {cylinder_high_byte, cylinder_low_byte} <= cyl + 16'h0001;
        end
      end
    end
    else if (sector_bad)
      transfer_count <= remaining[7:0];
  end

  // head field lives in drive_and_head_select; advanced here in chs and lba mode
  always_comb
  begin
    head_next = drive_and_head_select[3:0];
    if (sector_ok && remaining != 9'h001)
    begin
      if (lba_mode)
      begin
        if ({cylinder_high_byte, cylinder_low_byte, start_sector_or_lba_low} == 24'hff_ffff)
          head_next = drive_and_head_select[3:0] + 4'h1;
      end
      else if (start_sector_or_lba_low >= geom_spt)
      begin
        if ({4'h0, drive_and_head_select[3:0]} + 8'h01 >= geom_heads)
          head_next = 4'h0;
        else
          head_next = drive_and_head_select[3:0] + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state     <= svc_pkg::SVC_IDLE;
      remaining <= 9'h000;
      req_out   <= 1'b0;
      gap_cnt   <= 8'h00;
    end
    else
    begin
      unique case (state)
        svc_pkg::SVC_IDLE:
          if (cmd_write)
          begin
            state     <= svc_pkg::SVC_CHECK;
            remaining <= (transfer_count == 8'h00) ? 9'h100 : {1'b0, transfer_count};
            req_out   <= 1'b1;
          end
        svc_pkg::SVC_CHECK:
        begin
          if (gap_cnt != 8'h00)
          begin
            gap_cnt <= gap_cnt - 8'h01;
            req_out <= (gap_cnt == 8'h01);
          end
          else if (media_check_done)
            req_out <= 1'b0;
          if (sector_bad)
            state <= svc_pkg::SVC_DONE;
          else if (sector_ok)
          begin
            remaining <= remaining - 9'h001;
            if (remaining == 9'h001)
              state <= svc_pkg::SVC_DONE;
            else
              gap_cnt <= 8'(SECTOR_CYC);
          end
        end
        svc_pkg::SVC_DONE:
          state <= svc_pkg::SVC_IDLE;
        default:
          state <= svc_pkg::SVC_IDLE;
      endcase
    end
  end

  // status and error; drq never rises for this command
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      failure_cause   <= 8'h00;
      drive_condition <= 8'h50;
    end
    else if (cmd_write)
    begin
      failure_cause   <= 8'h00;
      drive_condition <= 8'h80;
    end
    else if (do_write && aw_addr == `SVC_OFF_OPCODE && w_strb[0]
             && state == svc_pkg::SVC_IDLE && drive_match)
    begin
      failure_cause   <= 8'h01 << `SVC_ERR_ABT;
      drive_condition <= 8'h51;
    end
    else
    begin
      if (sector_bad)
        failure_cause <= {1'b0, media_check_unc, 1'b0, media_check_idnf, 4'h0};
      if (state == svc_pkg::SVC_DONE)
      begin
        drive_condition                <= 8'h50;
        drive_condition[`SVC_ST_ERR]   <= failure_cause[`SVC_ERR_UNC]
                                          | failure_cause[`SVC_ERR_IDN]
                                          | failure_cause[`SVC_ERR_ABT];
      end
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (do_write && aw_addr == `SVC_OFF_IRQ_STAT && w_strb[0] && w_data[i])
          irq_status[i] <= 1'b0;
      end
      if (state == svc_pkg::SVC_DONE)
        irq_status[0] <= 1'b1;
      if (sector_bad)
        irq_status[1] <= 1'b1;
    end
  end

endmodule : svc_sector_verify

/* File: testbench/svc_media_model.sv */
// Purpose: behavioural medium checker answering sector requests
// Assumes: same clock as the block
// Notes:   flags toggle outside done so a stale value is never trusted
`timescale 1ns/1ps
module svc_media_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // request side
  input  wire logic        req,
  input  wire logic [27:0] addr,
  // control from the bench
  input  wire logic [3:0]  lat,
  input  wire logic [27:0] bad_addr,
  input  wire logic        bad_en,
  // answer
  output logic             done,
  output logic             uncorrectable_flag,
  output logic             idnf,
  output int               n_seen
);
  logic [3:0] cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {done, uncorrectable_flag, idnf, cnt} <= '0;
      n_seen <= 0;
    end
    else
    begin
      done <= 1'b0;
      uncorrectable_flag  <= ~uncorrectable_flag;
      idnf <= ~idnf;
      if (!req)
        cnt <= '0;
      else if (!done)
      begin
        if (cnt == lat)
        begin
          done   <= 1'b1;
          uncorrectable_flag    <= bad_en && addr == bad_addr;
          idnf   <= 1'b0;
          n_seen <= n_seen + 1;
          cnt    <= '0;
        end
        else
          cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : svc_media_model

/* File: testbench/svc_sva.sv */
// Purpose: port-level checks of the sector verify block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the design top, watches its ports only
`timescale 1ns/1ps
module svc_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // medium checker
  input wire logic        media_check_req,
  input wire logic        media_check_done,
  input wire logic [27:0] media_check_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_taken;
    media_check_req && media_check_done;
  endsequence
  sequence s_gap;
    !media_check_req [*8];
  endsequence
  a_req_holds: assert property (media_check_req && !media_check_done |=> media_check_req)
    else $error("sector request dropped before done");
  a_addr_steady: assert property (media_check_req && !media_check_done |=> $stable(media_check_addr))
    else $error("sector address moved while requested");
  a_req_gap: assert property (s_taken |=> s_gap)
    else $error("sector request too soon after done");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response not held");
  a_b_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during read data");
endmodule : svc_sva

bind svc_sector_verify svc_sva svc_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .media_check_req(media_check_req),
  .media_check_done(media_check_done), .media_check_addr(media_check_addr));

/* File: testbench/testbench.sv */
// Purpose: self-checking bench of the sector verify block
// Assumes: AXI4-Lite master tasks, medium model on the far side
// Notes:   task-file bytes read back in bits 7:0
`timescale 1ns/1ps
`include "svc_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  logic aclk, aresetn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, req, lba, done, uncorrectable_flag, idnf;
  logic irq, bad_en;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, v;
  logic [1:0] bresp, rresp;
  logic [27:0] addr, bad;
  logic [3:0] lat;
  int n_fail, n_tests, n_seen, n0;
  svc_sector_verify #(.DRIVE_ID(0)) svc_sector_verify_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .media_check_req(req), .media_check_addr(addr), .media_check_lba(lba),
    .media_check_done(done), .media_check_unc(uncorrectable_flag), .media_check_idnf(idnf), .irq(irq));
  svc_media_model svc_media_model_inst (.aclk(aclk), .aresetn(aresetn), .req(req),
    .addr(addr), .lat(lat), .bad_addr(bad), .bad_en(bad_en), .done(done), .uncorrectable_flag(uncorrectable_flag),
    .idnf(idnf), .n_seen(n_seen));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    awa <= a; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    if (i == 50) begin n_fail++; results(); end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdat;
    rr <= 1'b0;
    if (i == 50) begin n_fail++; results(); end
  endtask : rd
  // loads the task file, issues the opcode and polls until busy clears
  task automatic run(input logic [7:0] c, s, cl, ch, dh, op);
    int i;
    n0 = n_seen;
    wr(`SVC_OFF_COUNT, c); wr(`SVC_OFF_SECTOR, s); wr(`SVC_OFF_CYL_LO, cl);
    wr(`SVC_OFF_CYL_HI, ch);
    wr(`SVC_OFF_DEVHEAD, dh);
    wr(`SVC_OFF_OPCODE, op);
    for (i = 0; i < 4000; i++)
    begin
      rd(`SVC_OFF_COND, v);
      `CHK("drq", 1'b0, v[3])
      if (!v[7]) break;
    end
    if (i == 4000) begin n_fail++; results(); end
  endtask : run
  task automatic chk_tf(input logic [7:0] c, s, cl, ch, h, e, st, input int n);
    rd(`SVC_OFF_COUNT, v);   `CHK("count", c, v[7:0])
    rd(`SVC_OFF_SECTOR, v);  `CHK("sector", s, v[7:0])
    rd(`SVC_OFF_CYL_LO, v);  `CHK("cyl_lo", cl, v[7:0])
    rd(`SVC_OFF_CYL_HI, v);  `CHK("cyl_hi", ch, v[7:0])
    rd(`SVC_OFF_DEVHEAD, v); `CHK("head", h[3:0], v[3:0])
    rd(`SVC_OFF_CAUSE, v);   `CHK("error", e, v[7:0])
    rd(`SVC_OFF_COND, v);    `CHK("status", st, v[7:0])
    `CHK("sectors", n, n_seen - n0)
  endtask : chk_tf
  task automatic t_reset;
    rd(`SVC_OFF_COND, v);    `CHK("status", 8'h50, v[7:0])
    rd(`SVC_OFF_DEVHEAD, v); `CHK("devhead", 8'ha0, v[7:0])
    rd(`SVC_OFF_GEOM, v);    `CHK("geom", 32'h0000_3f10, v)
    rd(8'h2c, v);            `CHK("unmapped", 32'h0, v)
    `CHK("rresp", 2'b00, rresp)
    wr(`SVC_OFF_DEVHEAD, 8'hb0);
    wr(`SVC_OFF_OPCODE, 8'h40);
    rd(`SVC_OFF_COND, v);    `CHK("other_drive", 8'h50, v[7:0])
    `CHK("no_sectors", 0, n_seen)
    wr(`SVC_OFF_DEVHEAD, 8'ha0);
    wr(`SVC_OFF_OPCODE, 8'hec);
    rd(`SVC_OFF_CAUSE, v);   `CHK("abort", 8'h04, v[7:0])
    rd(`SVC_OFF_COND, v);    `CHK("status", 8'h51, v[7:0])
    $display("test reset done");
  endtask : t_reset
  task automatic t_lba;
    lat <= 4'h0;
    run(8'h03, 8'hfe, 8'hff, 8'h12, 8'he5, 8'h40);
    chk_tf(8'h00, 8'h00, 8'h00, 8'h13, 8'h05, 8'h00, 8'h50, 3);
    `CHK("lba", 1'b1, lba)
    $display("test lba done");
  endtask : t_lba
  task automatic t_256;
    lat <= 4'h7;
    run(8'h00, 8'hf0, 8'h00, 8'h00, 8'he0, 8'h41);
    chk_tf(8'h00, 8'hef, 8'h01, 8'h00, 8'h00, 8'h00, 8'h50, 256);
    $display("test 256 done");
  endtask : t_256
  task automatic t_unc;
    lat <= 4'h3; bad <= 28'h0000011; bad_en <= 1'b1;
    wr(`SVC_OFF_IRQ_MASK, 8'h03);
    run(8'h05, 8'h10, 8'h00, 8'h00, 8'he0, 8'h40);
    chk_tf(8'h04, 8'h11, 8'h00, 8'h00, 8'h00, 8'h40, 8'h51, 2);
    `CHK("irq", 1'b1, irq)
    wr(`SVC_OFF_IRQ_STAT, 8'h03);
    rd(`SVC_OFF_IRQ_STAT, v); `CHK("irq", 1'b0, irq)
    wr(`SVC_OFF_IRQ_MASK, 8'h00);
    bad_en <= 1'b0;
    $display("test error stop done");
  endtask : t_unc
  task automatic t_chs;
    run(8'h02, 8'h3f, 8'h02, 8'h01, 8'ha2, 8'h40);
    chk_tf(8'h00, 8'h01, 8'h02, 8'h01, 8'h03, 8'h00, 8'h50, 2);
    `CHK("lba", 1'b0, lba)
    rd(`SVC_OFF_IRQ_STAT, v); `CHK("done_bit", 1'b1, v[0])
    `CHK("masked", 1'b0, irq)
    wr(`SVC_OFF_IRQ_MASK, 8'h01);
    rd(`SVC_OFF_IRQ_STAT, v); `CHK("irq", 1'b1, irq)
    wr(`SVC_OFF_IRQ_STAT, 8'h01);
    rd(`SVC_OFF_IRQ_STAT, v); `CHK("irq", 1'b0, irq)
    $display("test chs done");
  endtask : t_chs
  initial
  begin
    {aresetn, awv, wv, br, arv, rr, bad_en} = '0;
    awa = '0; ara = '0; wd = '0; lat = '0; bad = '0;
    n_fail = 0; n_tests = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_lba();
    t_256();
    t_unc();
    t_chs();
    results();
  end
endmodule : testbench
